// *** dv/adc_low_power_entry_control_tb.sv ***
`timescale 1ns/1ps
module adc_low_power_entry_control_tb;
    typedef struct {logic [9:0] lvl; logic [7:0] ctl; logic [9:0] exp;} alpec_row_t;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic low_power_entry_i = 1'b0;
    logic comp_i;
    logic [7:0] reg_rdata_o, d, lo;
    logic irq_o, ref_switch_o, sample_o;
    logic [9:0] dac_code_o;
    logic [9:0] level = 10'h000;
    logic [2:0] channel_o;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    alpec_row_t rows [4] = '{'{10'h000, 8'h90, 10'h000}, '{10'h3ff, 8'hb5, 10'h3ff},
        '{10'h200, 8'hd2, 10'h200}, '{10'h155, 8'hf7, 10'h155}};

    always #50 clock_i = ~clock_i;

    alpec_top DUT (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .low_power_entry_i(low_power_entry_i), .comp_i(comp_i), .reg_rdata_o(reg_rdata_o),
        .irq_o(irq_o), .ref_switch_o(ref_switch_o), .sample_o(sample_o),
        .dac_code_o(dac_code_o), .channel_o(channel_o));
    alpec_comp_model u_comp (.level_i(level), .dac_code_i(dac_code_o), .comp_o(comp_i));

    // ====
    // tasks
    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd
    task automatic wait_done;
        d = 8'h00;
        for (int i = 0; i < 40 && d[7] !== 1'b1; i++)
            rd(4'h1);
        chk("done flag", 10'h001, {9'h0, d[7]});
    endtask : wait_done
    task automatic lp(input logic on);
        @(posedge clock_i);
        low_power_entry_i <= on;
    endtask : lp
    task automatic stop_test;
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            stop_test();
        end
    end

    // ====
    // sequence
    initial
    begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 7; a++)
        begin
            rd(a == 6 ? 4'hf : 4'(a));
            chk("reset read", 10'h000, {2'h0, d});
        end
        wr(4'h5, 8'h03);
        foreach (rows[i])
        begin
            level = rows[i].lvl;
            wr(4'h0, rows[i].ctl);
            wait_done();
            chk("channel", {7'h0, rows[i].ctl[2:0]}, {7'h0, channel_o});
            chk("dac code", rows[i].exp, dac_code_o);
            rd(4'h0);
            chk("ctrl a", {2'h0, rows[i].ctl & 8'h77}, {2'h0, d});
            rd(4'h2);
            lo = d;
            rd(4'h3);
            chk("result", rows[i].exp, {d, lo[7:6]});
            chk("irq", 10'h001, {9'h0, irq_o});
            wr(4'h4, 8'h01);
            @(posedge clock_i);
            #1 chk("irq", 10'h000, {9'h0, irq_o});
        end
        // entry while idle, reads and a start attempt while asleep
        lp(1'b1);
        rd(4'h3);
        chk("result high", 10'h000, {2'h0, d});
        rd(4'h2);
        chk("result low", 10'h000, {2'h0, d});
        rd(4'h0);
        chk("ctrl a", 10'h007, {2'h0, d});
        wr(4'h0, 8'h90);
        lp(1'b0);
        repeat (3) @(posedge clock_i);
        #1 chk("ref idle", 10'h000, {9'h0, ref_switch_o});
        rd(4'h0);
        chk("ctrl a", 10'h007, {2'h0, d});
        rd(4'h4);
        chk("abort flag", 10'h000, {9'h0, d[1]});
        // entry mid conversion, read back while still asleep
        level = 10'h2aa;
        wr(4'h0, 8'h93);
        repeat (14) @(posedge clock_i);
        rd(4'h1);
        chk("ctrl b busy", 10'h060, {2'h0, d});
        lp(1'b1);
        rd(4'h1);
        chk("ctrl b", 10'h000, {2'h0, d});
        chk("ref", 10'h000, {9'h0, ref_switch_o});
        chk("dac code", 10'h000, dac_code_o);
        lp(1'b0);
        rd(4'h4);
        chk("abort flag", 10'h001, {9'h0, d[1]});
        chk("irq abort", 10'h001, {9'h0, irq_o});
        wr(4'h4, 8'h02);
        repeat (30) @(posedge clock_i);
        rd(4'h1);
        chk("busy after wake", 10'h000, {9'h0, d[6]});
        chk("irq cleared", 10'h000, {9'h0, irq_o});
        wr(4'h0, 8'h93);
        wait_done();
        rd(4'h2);
        lo = d;
        rd(4'h3);
        chk("result", 10'h2aa, {d, lo[7:6]});
        // asynchronous reset during the sample phase of a conversion
        wr(4'h0, 8'h93);
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b1;
        @(posedge clock_i);
        #1 chk("reset dac", 10'h000, dac_code_o);
        chk("reset pins", 10'h000, {7'h0, ref_switch_o, sample_o, irq_o});
        @(posedge clock_i);
        rst_i <= 1'b0;
        rd(4'h1);
        chk("reset ctrl b", 10'h000, {2'h0, d});
        rd(4'h0);
        chk("reset ctrl a", 10'h000, {2'h0, d});
        stop_test();
    end
endmodule : adc_low_power_entry_control_tb

// *** dv/alpec_chk.sv ***
`timescale 1ns/1ps
module alpec_chk
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic low_power_entry_i,
    input wire logic comp_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic irq_o,
    input wire logic ref_switch_o,
    input wire logic sample_o,
    input wire logic [9:0] dac_code_o,
    input wire logic [2:0] channel_o
);
    // ====
    // sequences
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    sequence sample_run;
        sample_o [*8] ##1 sample_o [*5] ##1 !sample_o;
    endsequence
    sequence lp_read;
        low_power_entry_i ##1 reg_rd_i;
    endsequence
    // ====
    // properties
    a_lp_ref_off: assert property (low_power_entry_i |=> !ref_switch_o && !sample_o)
        else $error("reference still connected after low-power entry");
    a_no_self_start: assert property ($rose(ref_switch_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
        else $error("converter started without a write");
    a_ref_bound: assert property ($rose(ref_switch_o) |-> ##[1:30] !ref_switch_o)
        else $error("reference held too long");
    a_sample_len: assert property (@(posedge clock_i) disable iff (rst_i || low_power_entry_i)
        $rose(sample_o) |-> sample_run)
        else $error("sample phase length wrong");
    a_rd_quiet: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside read answer");
    a_lp_res_zero: assert property (lp_read ##0 reg_addr_i[3:1] == 3'b001 |=> reg_rdata_o == 8'h00)
        else $error("result not cleared by low-power entry");
    a_lp_ctrl_zero: assert property (lp_read ##0 reg_addr_i == 4'h0 |=> reg_rdata_o[7:4] == 4'h0)
        else $error("control not cleared by low-power entry");
    a_lp_flag_zero: assert property (lp_read ##0 reg_addr_i == 4'h1 |=> reg_rdata_o[7:5] == 3'h0)
        else $error("flags not cleared by low-power entry");
endmodule : alpec_chk

bind alpec_top alpec_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .low_power_entry_i(low_power_entry_i), .comp_i(comp_i), .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o), .ref_switch_o(ref_switch_o), .sample_o(sample_o),
    .dac_code_o(dac_code_o), .channel_o(channel_o));

// *** dv/alpec_comp_model.sv ***
`timescale 1ns/1ps
module alpec_comp_model
(
    input wire logic [9:0] level_i,
    input wire logic [9:0] dac_code_i,
    output logic comp_o
);
    // input sits half a step above its code, so no tie
    assign comp_o = {level_i, 1'b1} > {dac_code_i, 1'b0};
endmodule : alpec_comp_model

// *** rtl/alpec_result.sv ***
`timescale 1ns/1ps
module alpec_result
(
    input wire logic clock_i,
    input wire logic rst_i,
    alpec_res_if.store res
);
    logic [9:0] data_ff;
    logic [9:0] nxt_data;

    always_comb
    begin
        nxt_data = data_ff;
        if (res.clr)
        begin
            nxt_data = 10'h000;
        end
        else if (res.wr)
        begin
            nxt_data = res.wdata;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            data_ff <= 10'h000;
        end
        else
        begin
            data_ff <= nxt_data;
        end
    end

    assign res.rdata = data_ff;
endmodule : alpec_result

// *** rtl/alpec_top.sv ***
`timescale 1ns/1ps
`include "alpec_regs.svh"
// Overview of operation
// RULE1: low-power entry clears controls, flags, results (code keeps channel select, interrupt status and interrupt mask)
// RULE2: entry mid-conversion aborts and halts converter
// RULE3: after wake-up stay idle, no restart
// RULE4: software reprograms controls before next start
// RULE5: entry disconnects analog reference switch
// RULE6: result is 10-bit code, low/high split
// RULE7: low-power entry clears state machine synchronously
module alpec_top
    import alpec_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic low_power_entry_i,
    input wire logic comp_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_o,
    output logic ref_switch_o,
    output logic sample_o,
    output logic [9:0] dac_code_o,
    output logic [2:0] channel_o
);
    // ==========================================================
    // control registers
    // ==========================================================
    logic conv_start_bit_ff, nxt_conv_start_bit;
    logic [1:0] conv_operating_mode_ff, nxt_conv_operating_mode;
    logic analog_input_enable_ff, nxt_analog_input_enable;
    logic [2:0] chan_ff, nxt_chan;
    logic conv_done_flag_ff, nxt_conv_done_flag;
    logic [1:0] irq_stat_ff, nxt_irq_stat;
    logic [1:0] irq_mask_ff, nxt_irq_mask;
    logic wr_ctrl_a;
    logic start_req;
    logic conv_finish;
    logic abort_evt;
    alpec_state_t state_ff, nxt_state;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    assign wr_ctrl_a = reg_wr_i && hit(reg_addr_i, `ALPEC_ADDR_CTRL_A);
    assign start_req = wr_ctrl_a && reg_wdata_i[`ALPEC_CA_START];
    assign abort_evt = low_power_entry_i && (state_ff != ALPEC_IDLE);

    always_comb
    begin
        nxt_conv_start_bit = conv_start_bit_ff;
        nxt_conv_operating_mode = conv_operating_mode_ff;
        nxt_analog_input_enable = analog_input_enable_ff;
        nxt_chan = chan_ff;
        nxt_conv_done_flag = conv_done_flag_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_stat = irq_stat_ff;
        if (reg_wr_i && hit(reg_addr_i, `ALPEC_ADDR_IRQ_STAT))
        begin
            nxt_irq_stat = irq_stat_ff & ~reg_wdata_i[1:0];
        end
        if (reg_wr_i && hit(reg_addr_i, `ALPEC_ADDR_IRQ_MASK))
        begin
            nxt_irq_mask = reg_wdata_i[1:0];
        end
        if (abort_evt)
        begin
            nxt_irq_stat[`ALPEC_IRQ_ABORT] = 1'b1;
        end
        if (low_power_entry_i)
        begin
            nxt_conv_start_bit = 1'b0; // RULE1
            nxt_conv_operating_mode = 2'b00; // RULE1
            nxt_analog_input_enable = 1'b0; // RULE1
            nxt_conv_done_flag = 1'b0; // RULE1
        end
        else
        begin
            if (wr_ctrl_a)
            begin
                nxt_conv_start_bit = reg_wdata_i[`ALPEC_CA_START];
                nxt_conv_operating_mode = reg_wdata_i[`ALPEC_CA_MODE_LSB +: 2];
                nxt_analog_input_enable = reg_wdata_i[`ALPEC_CA_AIN_EN];
                nxt_chan = reg_wdata_i[`ALPEC_CA_CHAN_LSB +: 3];
            end
            if (start_req)
            begin
                nxt_conv_done_flag = 1'b0;
            end
            if (conv_finish)
            begin
                nxt_conv_start_bit = 1'b0;
                nxt_conv_done_flag = 1'b1;
                nxt_irq_stat[`ALPEC_IRQ_DONE] = 1'b1;
            end
            else if (reg_rd_i && hit(reg_addr_i, `ALPEC_ADDR_RES_HI))
            begin
                nxt_conv_done_flag = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            conv_start_bit_ff <= 1'b0;
            conv_operating_mode_ff <= 2'b00;
            analog_input_enable_ff <= 1'b0;
            chan_ff <= 3'h0;
            conv_done_flag_ff <= 1'b0;
            irq_stat_ff <= 2'h0;
            irq_mask_ff <= 2'h0;
        end
        else
        begin
            conv_start_bit_ff <= nxt_conv_start_bit;
            conv_operating_mode_ff <= nxt_conv_operating_mode;
            analog_input_enable_ff <= nxt_analog_input_enable;
            chan_ff <= nxt_chan;
            conv_done_flag_ff <= nxt_conv_done_flag;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    // ==========================================================
    // successive approximation engine
    // ==========================================================
    logic [7:0] cnt_ff, nxt_cnt;
    logic [9:0] sar_ff, nxt_sar;
    logic [3:0] bit_ff, nxt_bit;
    logic ref_ff, nxt_ref;
    logic sample_ff, nxt_sample;
    alpec_res_if res ();

    assign conv_finish = (state_ff == ALPEC_CONVERT) && (bit_ff == 4'h0)
        && !low_power_entry_i;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sar = sar_ff;
        nxt_bit = bit_ff;
        nxt_ref = ref_ff;
        nxt_sample = 1'b0;
        if (low_power_entry_i)
        begin
            nxt_state = ALPEC_IDLE; // RULE2 RULE7
            nxt_ref = 1'b0; // RULE5
            nxt_sar = 10'h000;
            nxt_cnt = 8'h00;
            nxt_bit = 4'h0;
        end
        else
        begin
            case (state_ff)
                ALPEC_IDLE:
                begin
                    // only a software start leaves idle
                    if (start_req && reg_wdata_i[`ALPEC_CA_AIN_EN]) // RULE3 RULE4
                    begin
                        nxt_state = ALPEC_SAMPLE;
                        nxt_ref = 1'b1;
                        nxt_cnt = `ALPEC_CONV_CYCLES;
                        nxt_sample = 1'b1;
                    end
                end
                ALPEC_SAMPLE:
                begin
                    nxt_sample = 1'b1;
                    nxt_cnt = cnt_ff - 8'h01;
                    if (cnt_ff == 8'h01)
                    begin
                        nxt_sample = 1'b0;
                        nxt_state = ALPEC_CONVERT;
                        nxt_sar = 10'h200;
                        nxt_bit = 4'h9;
                    end
                end
                ALPEC_CONVERT:
                begin
                    // keep or drop trial bit, then try the next one
                    nxt_sar[bit_ff] = comp_i;
                    if (bit_ff == 4'h0)
                    begin
                        nxt_state = ALPEC_IDLE;
                        nxt_ref = 1'b0;
                    end
                    else
                    begin
                        nxt_bit = bit_ff - 4'h1;
                        nxt_sar[bit_ff - 4'h1] = 1'b1;
                    end
                end
                default:
                begin
                    nxt_state = ALPEC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff <= ALPEC_IDLE;
            cnt_ff <= 8'h00;
            sar_ff <= 10'h000;
            bit_ff <= 4'h0;
            ref_ff <= 1'b0;
            sample_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sar_ff <= nxt_sar;
            bit_ff <= nxt_bit;
            ref_ff <= nxt_ref;
            sample_ff <= nxt_sample;
        end
    end

    assign res.clr = low_power_entry_i; // RULE1
    assign res.wr = conv_finish;
    assign res.wdata = {sar_ff[9:1], comp_i}; // RULE6

    alpec_result u_result
    (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .res(res)
    );

    // ==========================================================
    // read port and outputs
    // ==========================================================
    logic [7:0] rdata_ff, nxt_rdata;
    logic irq_ff;

    always_comb
    begin
        nxt_rdata = 8'h00;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `ALPEC_ADDR_CTRL_A: nxt_rdata = {conv_start_bit_ff, conv_operating_mode_ff,
                    analog_input_enable_ff, 1'b0, chan_ff};
                `ALPEC_ADDR_CTRL_B: nxt_rdata = {conv_done_flag_ff, (state_ff != ALPEC_IDLE),
                    ref_ff, 5'h00};
                `ALPEC_ADDR_RES_LO: nxt_rdata = {res.rdata[1:0], 6'h00}; // RULE6
                `ALPEC_ADDR_RES_HI: nxt_rdata = res.rdata[9:2]; // RULE6
                `ALPEC_ADDR_IRQ_STAT: nxt_rdata = {6'h00, irq_stat_ff};
                `ALPEC_ADDR_IRQ_MASK: nxt_rdata = {6'h00, irq_mask_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_ff <= 8'h00;
            irq_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign irq_o = irq_ff;
    assign ref_switch_o = ref_ff;
    assign sample_o = sample_ff;
    assign dac_code_o = sar_ff;
    assign channel_o = chan_ff;
endmodule : alpec_top

// *** shared/alpec_pkg.sv ***
package alpec_pkg;
    typedef enum logic [1:0] {
        ALPEC_IDLE = 2'b00,
        ALPEC_SAMPLE = 2'b01,
        ALPEC_CONVERT = 2'b10
    } alpec_state_t;
endpackage : alpec_pkg

// *** shared/alpec_regs.svh ***
`ifndef ALPEC_REGS_SVH
`define ALPEC_REGS_SVH
// register offsets (word index on the plain port)
`define ALPEC_ADDR_CTRL_A 4'h0
`define ALPEC_ADDR_CTRL_B 4'h1
`define ALPEC_ADDR_RES_LO 4'h2
`define ALPEC_ADDR_RES_HI 4'h3
`define ALPEC_ADDR_IRQ_STAT 4'h4
`define ALPEC_ADDR_IRQ_MASK 4'h5
// control a fields
`define ALPEC_CA_START 7
`define ALPEC_CA_MODE_LSB 5
`define ALPEC_CA_AIN_EN 4
`define ALPEC_CA_CHAN_LSB 0
// control b fields
`define ALPEC_CB_DONE 7
`define ALPEC_CB_BUSY 6
`define ALPEC_CB_REF_ON 5
// interrupt bits
`define ALPEC_IRQ_DONE 0
`define ALPEC_IRQ_ABORT 1
// sample phase length in clocks
`define ALPEC_CONV_CYCLES 8'h0d
`endif

// *** shared/alpec_res_if.sv ***
`timescale 1ns/1ps
interface alpec_res_if;
    logic wr;
    logic clr;
    logic [9:0] wdata;
    logic [9:0] rdata;
    modport ctrl (output wr, output clr, output wdata, input rdata);
    modport store (input wr, input clr, input wdata, output rdata);
endinterface : alpec_res_if
